// ---- core/mac_power_offload_regs.sv ----
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module mac_power_offload_regs import mac_po_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Flow control
	input wire logic rx_above_high,
	input wire logic rx_below_low,
	input wire logic pause_timer_expired,
	output logic pause_req,
	output logic [15:0] pause_time,
	// Low power idle
	input wire logic energy_saving_on,
	input wire logic tx_active,
	input wire logic [7:0] tx_pkt_count,
	output logic lpi_active,
	// Link and wake
	input wire logic link_up_pin,
	output logic wake_event,
	// Offload control
	output logic arp_reply_offload_en,
	output logic advert_offload_en,
	output logic arp_target_check_en,
	output logic solicit_remote_check_en,
	// USB errors and register 5 contents
	input wire logic usb_crc_err,
	input wire logic [7:0] rx_ctrl_value,
	// Interrupt
	output logic irq
);
	// =========================================================
	// Register state
	logic [3:0] pause_limit_ff;
	logic [3:0] pause_cnt_ff;
	logic [6:0] entry_time_ff;
	logic [6:0] exit_time_ff;
	logic [1:0] wake_en_ff;
	logic [3:0] offload_ff;
	logic [7:0] usb_crc_cnt_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic [7:0] rdata_ff;
	logic pause_req_ff;
	logic [15:0] pause_time_ff;
	logic wake_ff;

	// =========================================================
	// Address decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	wire wr_pause = wr && hit(addr, ADDR_PAUSE);
	wire wr_entry = wr && hit(addr, ADDR_ENTRY);
	wire wr_exit = wr && hit(addr, ADDR_EXIT);
	wire wr_wake = wr && hit(addr, ADDR_WAKE);
	wire wr_offload = wr && hit(addr, ADDR_OFFLOAD);
	wire wr_usberr = wr && hit(addr, ADDR_USBERR);
	wire wr_mask = wr && hit(addr, ADDR_IRQ_MASK);
	wire rd_usberr = rd && hit(addr, ADDR_USBERR);
	wire rd_stat = rd && hit(addr, ADDR_IRQ_STAT);

	// =========================================================
	// 2us step enable
	wire step;

	step_tick u_step (
		.clk(clk),
		.rst_n(rst_n),
		.tick(step)
	);

	// =========================================================
	// Pause frame repetition
	wire pause_room = (pause_cnt_ff < pause_limit_ff);
	wire pause_fire = pause_timer_expired && rx_above_high && pause_room;
	wire pause_hit_max = pause_fire && (pause_cnt_ff + 4'h1 == pause_limit_ff);
	logic [3:0] nxt_pause_cnt;

	// Low threshold reached ends the burst and rearms the count
	assign nxt_pause_cnt = rx_below_low ? 4'h0 :
		pause_fire ? pause_cnt_ff + 4'h1 : pause_cnt_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pause_cnt_ff <= 4'h0;
			pause_req_ff <= 1'b0;
			pause_time_ff <= 16'h0000;
		end else begin
			pause_cnt_ff <= nxt_pause_cnt;
			pause_req_ff <= pause_fire;
			if (pause_fire) begin
				pause_time_ff <= PAUSE_TIME_FULL;
			end
		end
	end

	assign pause_req = pause_req_ff;
	assign pause_time = pause_time_ff;

	// =========================================================
	// Low power idle
	typedef enum logic [1:0] {ACTIVE, IDLE_LPI, WAKING} lpi_state_t;
	lpi_state_t state_ff;
	lpi_state_t nxt_state;
	logic [7:0] step_cnt_ff;
	logic [7:0] nxt_step_cnt;
	// One spare bit so the count can pass a 7-bit limit
	wire entry_due = (step_cnt_ff > {1'b0, entry_time_ff});
	wire exit_due = (step_cnt_ff >= {1'b0, exit_time_ff});
	wire tx_pending = (tx_pkt_count != 8'h00);
	wire lpi_enter = (state_ff == ACTIVE) && energy_saving_on &&
		!tx_active && entry_due;
	wire step_sat = (step_cnt_ff == 8'hFF);

	always_comb begin
		nxt_state = state_ff;
		nxt_step_cnt = step_cnt_ff;
		unique case (state_ff)
			ACTIVE: begin
				if (tx_active || !energy_saving_on) begin
					nxt_step_cnt = 8'h00;
				end else if (lpi_enter) begin
					nxt_state = IDLE_LPI;
					nxt_step_cnt = 8'h00;
				end else if (step && !step_sat) begin
					nxt_step_cnt = step_cnt_ff + 8'h01;
				end
			end
			IDLE_LPI: begin
				if (tx_pending) begin
					nxt_state = WAKING;
					nxt_step_cnt = 8'h00;
				end
			end
			WAKING: begin
				if (exit_due) begin
					nxt_state = ACTIVE;
					nxt_step_cnt = 8'h00;
				end else if (step) begin
					nxt_step_cnt = step_cnt_ff + 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ACTIVE;
			step_cnt_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			step_cnt_ff <= nxt_step_cnt;
		end
	end

	// Still low power while the leave timer runs
	assign lpi_active = (state_ff != ACTIVE);

	// =========================================================
	// Link pin sync and wake
	logic [2:0] link_sync_ff;
	logic link_ff;
	wire link_agree = (link_sync_ff[1] == link_sync_ff[2]);
	wire link_new = link_sync_ff[2];
	wire link_rise = link_agree && link_new && !link_ff;
	wire link_fall = link_agree && !link_new && link_ff;
	wire wake_up = link_rise && wake_en_ff[WAKE_UP_BIT];
	wire wake_down = link_fall && wake_en_ff[WAKE_DOWN_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_sync_ff <= 3'h0;
			link_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			link_sync_ff <= {link_sync_ff[1:0], link_up_pin};
			if (link_agree) begin
				link_ff <= link_new;
			end
			wake_ff <= wake_up || wake_down;
		end
	end

	assign wake_event = wake_ff;

	// =========================================================
	// Offload enables
	assign arp_reply_offload_en = offload_ff[OFL_ARP_BIT];
	assign advert_offload_en = offload_ff[OFL_NA_BIT];
	assign arp_target_check_en = offload_ff[OFL_ARPCHK_BIT];
	assign solicit_remote_check_en = offload_ff[OFL_NSCHK_BIT];

	// =========================================================
	// USB CRC error counter
	// Clear-on-read is disabled while register 5 holds a nonzero value
	wire usb_rd_clr = rd_usberr && (rx_ctrl_value == 8'h00);
	wire usb_clr = usb_rd_clr || wr_usberr;
	wire usb_sat = (usb_crc_cnt_ff == 8'hFF);
	logic [7:0] nxt_usb_crc_cnt;

	// An error in the clearing cycle survives as a count of one
	assign nxt_usb_crc_cnt = usb_clr ? {7'h00, usb_crc_err} :
		(usb_crc_err && !usb_sat) ? usb_crc_cnt_ff + 8'h01 :
		usb_crc_cnt_ff;

	// =========================================================
	// Interrupt status
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] nxt_irq_stat;

	always_comb begin
		irq_set = '0;
		irq_set[IRQ_LINK_UP] = wake_up;
		irq_set[IRQ_LINK_DOWN] = wake_down;
		irq_set[IRQ_LPI_ENTER] = lpi_enter;
		irq_set[IRQ_USB_CRC] = usb_crc_err;
		irq_set[IRQ_PAUSE_LIMIT] = pause_hit_max;
	end

	// Set beats the read clear
	assign nxt_irq_stat = (rd_stat ? '0 : irq_stat_ff) | irq_set;
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// =========================================================
	// Software registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pause_limit_ff <= PAUSE_LIMIT_RST;
			entry_time_ff <= ENTRY_RST;
			exit_time_ff <= EXIT_RST;
			wake_en_ff <= WAKE_RST;
			offload_ff <= OFFLOAD_RST;
			usb_crc_cnt_ff <= 8'h00;
			irq_stat_ff <= '0;
			irq_mask_ff <= IRQ_MASK_RST;
		end else begin
			if (wr_pause) pause_limit_ff <= wdata[3:0];
			if (wr_entry) entry_time_ff <= wdata[6:0];
			if (wr_exit) exit_time_ff <= wdata[6:0];
			if (wr_wake) wake_en_ff <= wdata[1:0];
			if (wr_offload) offload_ff <= wdata[3:0];
			if (wr_mask) irq_mask_ff <= wdata[IRQ_W-1:0];
			usb_crc_cnt_ff <= nxt_usb_crc_cnt;
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	// =========================================================
	// Read path
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		unique case (addr)
			ADDR_PAUSE: rd_mux = {pause_cnt_ff, pause_limit_ff};
			ADDR_ENTRY: rd_mux = {1'b0, entry_time_ff};
			ADDR_EXIT: rd_mux = {energy_saving_on, exit_time_ff};
			ADDR_WAKE: rd_mux = {6'h00, wake_en_ff};
			ADDR_OFFLOAD: rd_mux = {4'h0, offload_ff};
			ADDR_TXCNT: rd_mux = tx_pkt_count;
			ADDR_USBERR: rd_mux = usb_crc_cnt_ff;
			ADDR_IRQ_STAT: rd_mux = {3'h0, irq_stat_ff};
			ADDR_IRQ_MASK: rd_mux = {3'h0, irq_mask_ff};
			default: rd_mux = 8'h00;
		endcase
	end

	// Data stand only in the cycle after the read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= rd ? rd_mux : 8'h00;
		end
	end

	assign rdata = rdata_ff;
endmodule : mac_power_offload_regs
`default_nettype wire

// ---- core/step_tick.sv ----
`timescale 1ns/100ps
`default_nettype none
module step_tick import mac_po_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Enable pulse
	output logic tick
);
	localparam logic [STEP_W-1:0] LAST = STEP_W'(STEP_CYCLES - 1);
	logic [STEP_W-1:0] cnt_ff;
	logic [STEP_W-1:0] nxt_cnt;
	wire wrap = (cnt_ff == LAST);

	assign nxt_cnt = wrap ? '0 : cnt_ff + 1'b1;
	assign tick = wrap;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : step_tick
`default_nettype wire

// ---- pkg/mac_po_pkg.sv ----
// Operation
// - Count pause frames sent until receive buffer drops to low threshold.
// - On pause timeout above high threshold, send FFFFH pause, up to 4-bit max.
// - Enter low power idle after transmit idle exceeds 7-bit entry time, 2us steps.
// - In low power idle with pending packets, leave after 7-bit leave time.
// - Link loss wakes only while the link-down wake enable is 1.
// - Link up wakes only while the link-up wake enable, bit 0, is 1.
// - Bit 3 set checks the solicitation remote address; clear skips it.
// - Bit 2 set checks the ARP destination IP; clear ignores it.
// - Neighbour advertisement offload runs only while bit 1 is set.
// - ARP reply offload runs only while bit 0 is set.
// - An 8-bit read-only field shows packets held in the transmit buffer.
// - Each USB packet with data CRC error increments an 8-bit counter; here the counter holds at FFH instead of counting on.
// - Reading the USB error counter clears it only when register 5 is zero.
// - Any write to the USB error counter clears it.
package mac_po_pkg;
	// =========================================================
	// Register offsets
	localparam logic [7:0] ADDR_PAUSE = 8'h3D;
	localparam logic [7:0] ADDR_ENTRY = 8'h3E;
	localparam logic [7:0] ADDR_EXIT = 8'h3F;
	localparam logic [7:0] ADDR_WAKE = 8'h51;
	localparam logic [7:0] ADDR_OFFLOAD = 8'h52;
	localparam logic [7:0] ADDR_TXCNT = 8'h81;
	localparam logic [7:0] ADDR_USBERR = 8'h82;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'hA0;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hA1;
	// =========================================================
	// Reset values
	localparam logic [3:0] PAUSE_LIMIT_RST = 4'h4;
	localparam logic [6:0] ENTRY_RST = 7'h05;
	localparam logic [6:0] EXIT_RST = 7'h0F;
	localparam logic [1:0] WAKE_RST = 2'h1;
	localparam logic [3:0] OFFLOAD_RST = 4'h0;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
	// =========================================================
	// Field positions
	localparam int WAKE_UP_BIT = 0;
	localparam int WAKE_DOWN_BIT = 1;
	localparam int OFL_ARP_BIT = 0;
	localparam int OFL_NA_BIT = 1;
	localparam int OFL_ARPCHK_BIT = 2;
	localparam int OFL_NSCHK_BIT = 3;
	localparam int EXIT_EN_BIT = 7;
	// Interrupt status bits
	localparam int IRQ_LINK_UP = 0;
	localparam int IRQ_LINK_DOWN = 1;
	localparam int IRQ_LPI_ENTER = 2;
	localparam int IRQ_USB_CRC = 3;
	localparam int IRQ_PAUSE_LIMIT = 4;
	localparam int IRQ_W = 5;
	// =========================================================
	// Timing
	localparam logic [15:0] PAUSE_TIME_FULL = 16'hFFFF;
	localparam int CLK_PERIOD_NS = 50;
	localparam int STEP_NS = 2000;
	localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
	localparam int STEP_W = $clog2(STEP_CYCLES);
endpackage : mac_po_pkg

// ---- verification/mac_po_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// =========================================
// Link partner: link pin and pause timer
module mac_po_partner (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Controls from the bench
	input wire logic link_cmd,
	input wire logic kick,
	// Device side
	input wire logic pause_req,
	output logic link_up_pin,
	output logic pause_timer_expired,
	output logic [7:0] n_pause
);
	logic [3:0] dly_ff;
	// Pin moves off the clock grid, as a real PHY would
	initial link_up_pin = 1'b0;
	always @(link_cmd) link_up_pin <= #13 link_cmd;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_ff <= 4'h0;
			n_pause <= 8'h00;
		end else begin
			dly_ff <= {dly_ff[2:0], pause_req};
			n_pause <= n_pause + {7'h00, pause_req};
		end
	end
	// Each pause sent times out four cycles later
	assign pause_timer_expired = kick | dly_ff[3];
endmodule : mac_po_partner
`default_nettype wire

// ---- verification/mac_power_offload_regs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module mac_po_monitor import mac_po_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic rx_above_high,
	input wire logic pause_timer_expired,
	input wire logic pause_req,
	input wire logic [15:0] pause_time,
	input wire logic energy_saving_on,
	input wire logic tx_active,
	input wire logic [7:0] tx_pkt_count,
	input wire logic lpi_active,
	input wire logic wake_event,
	input wire logic arp_reply_offload_en,
	input wire logic advert_offload_en,
	input wire logic arp_target_check_en,
	input wire logic solicit_remote_check_en,
	input wire logic usb_crc_err
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [3:0] ofl = {solicit_remote_check_en, arp_target_check_en,
		advert_offload_en, arp_reply_offload_en};
	// =========================================
	// Assertions
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside answer cycle");
	a_pause_cause: assert property (
		pause_req |-> $past(pause_timer_expired && rx_above_high))
		else $error("pause sent without timeout above high mark");
	a_pause_value: assert property (
		pause_req |-> pause_time == PAUSE_TIME_FULL)
		else $error("pause value wrong");
	a_pause_single: assert property (pause_req |=> !pause_req)
		else $error("pause request longer than one cycle");
	a_offload_write: assert property (
		wr && addr == ADDR_OFFLOAD |=> ofl == $past(wdata[3:0]))
		else $error("offload enables do not follow write");
	a_txcnt_read: assert property (
		rd && addr == ADDR_TXCNT |=> rdata == $past(tx_pkt_count))
		else $error("tx count read wrong");
	a_lpi_entry: assert property (
		$rose(lpi_active) |-> $past(energy_saving_on && !tx_active))
		else $error("idle entered while active or disabled");
	a_usb_wrclear: assert property (
		(wr && addr == ADDR_USBERR && !usb_crc_err) ##1 !usb_crc_err
		##1 (rd && addr == ADDR_USBERR && !usb_crc_err) |=> rdata == 8'h00)
		else $error("usb counter not cleared by write");
	a_wake_pulse: assert property (wake_event |=> !wake_event)
		else $error("wake pulse longer than one cycle");
	c_pause: cover property (pause_req);
	c_lpi: cover property ($rose(lpi_active));
	c_wake: cover property (wake_event);
endmodule : mac_po_monitor
bind mac_power_offload_regs mac_po_monitor i_mac_po_monitor (.clk, .rst_n,
	.addr, .wdata, .wr, .rd, .rdata, .rx_above_high, .pause_timer_expired,
	.pause_req, .pause_time, .energy_saving_on, .tx_active, .tx_pkt_count,
	.lpi_active, .wake_event, .arp_reply_offload_en, .advert_offload_en,
	.arp_target_check_en, .solicit_remote_check_en, .usb_crc_err);
`default_nettype wire

// ---- verification/mac_power_offload_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module mac_power_offload_regs_tb_top import mac_po_pkg::*;;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, rx_above_high = 0, kick = 0;
	logic rx_below_low = 0, energy_saving_on = 0, tx_active = 0;
	logic usb_crc_err = 0, link_cmd = 0;
	logic [7:0] addr = 0, wdata = 0, tx_pkt_count = 0, rx_ctrl_value = 0;
	logic [7:0] rdata, n_pause;
	logic [15:0] pause_time;
	logic [3:0] ofl;
	logic pause_req, pause_timer_expired, lpi_active, link_up_pin;
	logic wake_event, irq;
	int n_mismatch = 0, n_checks = 0, n_wake = 0, cyc = 0;
	logic [7:0] ra [6] = '{8'h3D, 8'h3E, 8'h3F, 8'h51, 8'h52, 8'h10};
	logic [7:0] rv [6] = '{8'h04, 8'h05, 8'h0F, 8'h01, 8'h00, 8'h00};
	mac_power_offload_regs i_mac_power_offload_regs (.clk, .rst_n, .addr,
		.wdata, .wr, .rd, .rdata, .rx_above_high, .rx_below_low,
		.pause_timer_expired, .pause_req, .pause_time, .energy_saving_on,
		.tx_active, .tx_pkt_count, .lpi_active, .link_up_pin, .wake_event,
		.arp_reply_offload_en(ofl[0]), .advert_offload_en(ofl[1]),
		.arp_target_check_en(ofl[2]), .solicit_remote_check_en(ofl[3]),
		.usb_crc_err, .rx_ctrl_value, .irq);
	mac_po_partner i_mac_po_partner (.clk, .rst_n, .link_cmd, .kick,
		.pause_req, .link_up_pin, .pause_timer_expired, .n_pause);
	// =========================================
	// Clock, timeout, wake counting
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (wake_event === 1'b1) n_wake++;
		if (cyc == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// =========================================
	// Access tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wait_c(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_c
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		// Let the written register settle before anyone looks at it
		#1;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, e});
	endtask : rd_chk
	task automatic usb_crc_pulses(input int n);
		repeat (n) begin
			@(posedge clk) usb_crc_err <= 1'b1;
			@(posedge clk) usb_crc_err <= 1'b0;
		end
	endtask : usb_crc_pulses
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// =========================================
	// Tests
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i]);
		// Wake: enable up only, then down only, with and without mask
		wr_reg(ADDR_IRQ_MASK, 8'h03);
		link_cmd <= 1'b1;
		wait_c(10);
		chk(n_wake, 1);
		chk(irq, 1'b1);
		rd_chk(ADDR_IRQ_STAT, 8'h01);
		chk(irq, 1'b0);
		link_cmd <= 1'b0;
		wait_c(10);
		chk(n_wake, 1);
		rd_chk(ADDR_IRQ_STAT, 8'h00);
		wr_reg(ADDR_WAKE, 8'h02);
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		link_cmd <= 1'b1;
		wait_c(10);
		chk(n_wake, 1);
		link_cmd <= 1'b0;
		wait_c(10);
		chk(n_wake, 2);
		chk(irq, 1'b0);
		rd_chk(ADDR_IRQ_STAT, 8'h02);
		// Offload enables one at a time
		for (int i = 0; i < 4; i++) begin
			wr_reg(ADDR_OFFLOAD, 8'h01 << i);
			chk(ofl, 4'h1 << i);
		end
		// Transmit count is read-only
		tx_pkt_count <= 8'h5A;
		wr_reg(ADDR_TXCNT, 8'hFF);
		rd_chk(ADDR_TXCNT, 8'h5A);
		tx_pkt_count <= 8'h00;
		// USB error counter: read clear gated by register 5, write clear
		rx_ctrl_value <= 8'h01;
		usb_crc_pulses(3);
		rd_chk(ADDR_USBERR, 8'h03);
		rd_chk(ADDR_USBERR, 8'h03);
		rx_ctrl_value <= 8'h00;
		rd_chk(ADDR_USBERR, 8'h03);
		rd_chk(ADDR_USBERR, 8'h00);
		usb_crc_pulses(2);
		wr_reg(ADDR_USBERR, 8'hA5);
		rd_chk(ADDR_USBERR, 8'h00);
		// Repeated pause stops at a maximum of two
		wr_reg(ADDR_PAUSE, 8'h02);
		rx_above_high <= 1'b1;
		@(posedge clk) kick <= 1'b1;
		@(posedge clk) kick <= 1'b0;
		wait_c(20);
		chk(n_pause, 2);
		chk(pause_time, 16'hFFFF);
		rd_chk(ADDR_PAUSE, 8'h22);
		rx_above_high <= 1'b0;
		@(posedge clk) rx_below_low <= 1'b1;
		@(posedge clk) rx_below_low <= 1'b0;
		rd_chk(ADDR_PAUSE, 8'h02);
		// Sticky usb error and pause limit events, read clears them
		rd_chk(ADDR_IRQ_STAT, 8'h18);
		// Idle entry after more than 2 ticks, leave after 3 ticks
		wr_reg(ADDR_ENTRY, 8'h02);
		wr_reg(ADDR_EXIT, 8'h03);
		energy_saving_on <= 1'b1;
		wait_c(60);
		chk(lpi_active, 1'b0);
		wait_c(140);
		chk(lpi_active, 1'b1);
		rd_chk(ADDR_IRQ_STAT, 8'h04);
		rd_chk(ADDR_EXIT, 8'h83);
		tx_pkt_count <= 8'h01;
		wait_c(30);
		chk(lpi_active, 1'b1);
		// Look before idle timing can pass entry again with packets pending
		wait_c(100);
		chk(lpi_active, 1'b0);
		tx_pkt_count <= 8'h00;
		tx_active <= 1'b1;
		wait_c(200);
		chk(lpi_active, 1'b0);
		tally_and_finish();
	end
endmodule : mac_power_offload_regs_tb_top
`default_nettype wire
